// ===== rtl/acqsc_pkg.sv
// constants for the acquisition status and chain control block
package acqsc_pkg;
   // address windows and offsets
   localparam logic [15:0] ACQSC_BASE_BLK    = 16'h0200;
   localparam logic [15:0] ACQSC_BASE_NBLK   = 16'h0300;
   localparam logic [15:0] ACQSC_WIN_SIZE    = 16'h0100;
   localparam logic [7:0]  ACQSC_OFF_SR_HI   = 8'h5a;
   localparam logic [7:0]  ACQSC_OFF_SR_LO   = 8'h5b;
   localparam logic [7:0]  ACQSC_OFF_ACC1    = 8'h5c;
   // high status byte fields
   localparam int ACQSC_B_CUR_DONE  = 0;
   localparam int ACQSC_B_VOLT_DONE = 1;
   localparam int ACQSC_B_ITMP_DONE = 2;
   localparam int ACQSC_B_ETMP_DONE = 3;
   localparam int ACQSC_B_CUR_OVR   = 4;
   localparam int ACQSC_B_VOLT_OVR  = 5;
   localparam int ACQSC_B_GAIN_CHG  = 6;
   // low status byte fields
   localparam int ACQSC_B_VHIGH     = 4;
   localparam int ACQSC_B_SHUNT     = 7;
   // chain control fields
   localparam int ACQSC_B_AUTO_GAIN = 0;
   localparam int ACQSC_B_VC_CHOP   = 1;
   localparam int ACQSC_B_INT_CHOP  = 2;
   localparam int ACQSC_B_EXT_CHOP  = 3;
   localparam int ACQSC_B_LPF       = 4;
   localparam int ACQSC_B_CUR_COMP  = 5;
   localparam int ACQSC_B_VOLT_COMP = 6;
   localparam int ACQSC_B_TEMP_COMP = 7;
   localparam int ACQSC_MASK_SHIFT  = 8;
   // top bit of the per-channel chopper activity field
   localparam int ACQSC_CHOP_MSB    = 3;
   localparam logic [7:0]  ACQSC_ACC1_RST   = 8'he1;
   localparam logic [15:0] ACQSC_VHIGH_CODE = 16'hdac0;
   localparam logic [7:0]  ACQSC_ZERO8      = 8'h00;
endpackage

// ===== rtl/acqsc_top.sv
// acquisition status flags and chain control register
//
// Functional notes
// - External temperature done sets status high bit 3; write one clears.
// - Internal temperature done sets status high bit 2; write one clears.
// - Voltage done sets status high bit 1; write one clears.
// - Current done sets status high bit 0; write one clears.
// - No interrupt for temperature, gain-change or overwrite flags.
// - New result latched before previous was read sets overwrite flag.
// - Status low bit 7 shows shunt open, valid with check enabled in normal mode.
// - Status low bit 4 high while voltage result at or above 0xdac0.
// - Status low bits 3..0 show chopper activity per channel.
// - Status low byte at 0x5b is read-only; writes ignored.
// - Chain control register accepts only full 16-bit accesses.
// - Control bit 7..0 written only when mask bit eight higher is one.
// - Control bit 7 enables temperature offset and gain compensation.
// - Control bit 6 enables voltage offset and gain compensation.
// - Offsets decode from base 0x0200 blocking and 0x300 non-blocking.
// - Bit 5 enables current compensation, bit 4 the low-pass filter.
// - Bits 3, 2, 1 enable external, internal, volt/current chopper.
// - Bit 0 selects automatic gain; clear uses manual three-bit gain.
`timescale 1ns/1ps
module acqsc_top
   import acqsc_pkg::*;
(
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic [15:0] ADDR_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   input  wire logic        WIDE_I,
   input  wire logic [15:0] WDATA_I,
   output logic      [15:0] RDATA_O,
   output logic             ACC_ERR_O,
   input  wire logic        ETMP_DONE_I,
   input  wire logic        ITMP_DONE_I,
   input  wire logic        VOLT_DONE_I,
   input  wire logic        CUR_DONE_I,
   input  wire logic [15:0] VOLT_RESULT_I,
   input  wire logic        VOLT_RESULT_RD_I,
   input  wire logic        CUR_RESULT_RD_I,
   input  wire logic        GAIN_CHANGED_I,
   input  wire logic        SHUNT_OPEN_I,
   input  wire logic        SHUNT_CHECK_ENABLE_I,
   input  wire logic        NORMAL_MODE_I,
   input  wire logic [2:0]  MANUAL_GAIN_SETTING_I,
   input  wire logic [3:0]  CHOP_ACTIVE_I,
   output logic             TEMP_COMPENSATION_ENABLE_O,
   output logic             VOLTAGE_COMPENSATION_ENABLE_O,
   output logic             CURRENT_COMPENSATION_ENABLE_O,
   output logic             LOWPASS_ENABLE_O,
   output logic             EXT_TEMP_CHOPPER_O,
   output logic             INT_TEMP_CHOPPER_O,
   output logic             VOLT_CURR_CHOPPER_ENABLE_O,
   output logic             AUTO_GAIN_ENABLE_O,
   output logic [2:0]       MANUAL_GAIN_O
);

   // ************************************************************
   // address decode
   // ************************************************************

   logic [7:0]  off;
   logic        in_win;
   logic        hit_hi;
   logic        hit_lo;
   logic        hit_acc;
   logic        acc_ok;
   logic [7:0]  sr_hi;
   logic        etmp_done_r;
   logic        itmp_done_r;
   logic        volt_done_r;
   logic        cur_done_r;
   logic        volt_ovr_r;
   logic        cur_ovr_r;
   logic        gain_chg_r;
   logic [7:0]  acc1_r;
   logic [7:0]  sr_lo;
   logic        volt_unread_r;
   logic        cur_unread_r;
   logic [15:0] rdata_nxt;

   // true when the address falls in the given window
   function automatic logic acqsc_in(input logic [15:0] a,
                                     input logic [15:0] base);
      acqsc_in = (a >= base) && (a < (base + ACQSC_WIN_SIZE));
   endfunction

   always_comb
   begin
      in_win = acqsc_in(ADDR_I, ACQSC_BASE_BLK) ||
               acqsc_in(ADDR_I, ACQSC_BASE_NBLK);
      off    = ADDR_I[7:0];
   end

   // true when the decoded offset names the given register
   function automatic logic acqsc_hit(input logic       win,
                                      input logic [7:0] o,
                                      input logic [7:0] target);
      acqsc_hit = win && (o == target);
   endfunction

   assign hit_hi  = acqsc_hit(in_win, off, ACQSC_OFF_SR_HI);
   assign hit_lo  = acqsc_hit(in_win, off, ACQSC_OFF_SR_LO);
   assign hit_acc = acqsc_hit(in_win, off, ACQSC_OFF_ACC1);
   assign acc_ok  = hit_acc && WIDE_I;

   // ************************************************************
   // sticky status flags
   // ************************************************************

   // next value of one write-one-to-clear flag; a set beats the clear
   function automatic logic acqsc_w1c(input logic cur, input logic set,
                                      input logic clr);
      acqsc_w1c = set | (cur & ~clr);
   endfunction

   logic       clr_en;
   logic [7:0] clr_bits;
   logic       volt_ovr_set;
   logic       cur_ovr_set;

   assign clr_en   = WR_I && hit_hi;
   assign clr_bits = clr_en ? WDATA_I[7:0] : ACQSC_ZERO8;

   // result latched while the previous one is still unread
   assign volt_ovr_set = VOLT_DONE_I && volt_unread_r && !VOLT_RESULT_RD_I;
   assign cur_ovr_set  = CUR_DONE_I && cur_unread_r && !CUR_RESULT_RD_I;

   // voltage result waiting to be read
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         volt_unread_r <= 1'b0;
      else
         volt_unread_r <= VOLT_DONE_I | (volt_unread_r & ~VOLT_RESULT_RD_I);
   end

   // current result waiting to be read
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         cur_unread_r <= 1'b0;
      else
         cur_unread_r <= CUR_DONE_I | (cur_unread_r & ~CUR_RESULT_RD_I);
   end

   // sticky flags are polled only, no interrupt path
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         etmp_done_r <= 1'b0;
      else
         etmp_done_r <= acqsc_w1c(etmp_done_r, ETMP_DONE_I,
                                  clr_bits[ACQSC_B_ETMP_DONE]);
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         itmp_done_r <= 1'b0;
      else
         itmp_done_r <= acqsc_w1c(itmp_done_r, ITMP_DONE_I,
                                  clr_bits[ACQSC_B_ITMP_DONE]);
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         volt_done_r <= 1'b0;
      else
         volt_done_r <= acqsc_w1c(volt_done_r, VOLT_DONE_I,
                                  clr_bits[ACQSC_B_VOLT_DONE]);
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         cur_done_r <= 1'b0;
      else
         cur_done_r <= acqsc_w1c(cur_done_r, CUR_DONE_I,
                                 clr_bits[ACQSC_B_CUR_DONE]);
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         volt_ovr_r <= 1'b0;
      else
         volt_ovr_r <= acqsc_w1c(volt_ovr_r, volt_ovr_set,
                                 clr_bits[ACQSC_B_VOLT_OVR]);
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         cur_ovr_r <= 1'b0;
      else
         cur_ovr_r <= acqsc_w1c(cur_ovr_r, cur_ovr_set,
                                clr_bits[ACQSC_B_CUR_OVR]);
   end

   // gain change flag, polled like the others
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         gain_chg_r <= 1'b0;
      else
         gain_chg_r <= acqsc_w1c(gain_chg_r, GAIN_CHANGED_I,
                                 clr_bits[ACQSC_B_GAIN_CHG]);
   end

   // high status byte; the low-voltage reset flag lives elsewhere
   always_comb
   begin
      sr_hi                    = ACQSC_ZERO8;
      sr_hi[ACQSC_B_ETMP_DONE] = etmp_done_r;
      sr_hi[ACQSC_B_ITMP_DONE] = itmp_done_r;
      sr_hi[ACQSC_B_VOLT_DONE] = volt_done_r;
      sr_hi[ACQSC_B_CUR_DONE]  = cur_done_r;
      sr_hi[ACQSC_B_VOLT_OVR]  = volt_ovr_r;
      sr_hi[ACQSC_B_CUR_OVR]   = cur_ovr_r;
      sr_hi[ACQSC_B_GAIN_CHG]  = gain_chg_r;
   end

   // ************************************************************
   // live status byte
   // ************************************************************

   always_comb
   begin
      sr_lo = ACQSC_ZERO8;
      sr_lo[ACQSC_B_SHUNT] = SHUNT_OPEN_I && SHUNT_CHECK_ENABLE_I &&
                             NORMAL_MODE_I;
      sr_lo[ACQSC_B_VHIGH] = (VOLT_RESULT_I >= ACQSC_VHIGH_CODE);
      sr_lo[ACQSC_CHOP_MSB:0] = CHOP_ACTIVE_I;
   end

   // ************************************************************
   // chain control register
   // ************************************************************

   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         acc1_r <= ACQSC_ACC1_RST;
      else if (WR_I && acc_ok)
         acc1_r <= (WDATA_I[15:ACQSC_MASK_SHIFT] & WDATA_I[7:0]) |
                   (~WDATA_I[15:ACQSC_MASK_SHIFT] & acc1_r);
   end

   assign TEMP_COMPENSATION_ENABLE_O    = acc1_r[ACQSC_B_TEMP_COMP];
   assign VOLTAGE_COMPENSATION_ENABLE_O = acc1_r[ACQSC_B_VOLT_COMP];
   assign CURRENT_COMPENSATION_ENABLE_O = acc1_r[ACQSC_B_CUR_COMP];
   assign LOWPASS_ENABLE_O              = acc1_r[ACQSC_B_LPF];
   assign EXT_TEMP_CHOPPER_O            = acc1_r[ACQSC_B_EXT_CHOP];
   assign INT_TEMP_CHOPPER_O            = acc1_r[ACQSC_B_INT_CHOP];
   assign VOLT_CURR_CHOPPER_ENABLE_O    = acc1_r[ACQSC_B_VC_CHOP];
   assign AUTO_GAIN_ENABLE_O            = acc1_r[ACQSC_B_AUTO_GAIN];
   // manual gain passed on only when auto gain is off
   assign MANUAL_GAIN_O = acc1_r[ACQSC_B_AUTO_GAIN] ? 3'h0 :
                          MANUAL_GAIN_SETTING_I;

   // ************************************************************
   // read data
   // ************************************************************

   always_comb
   begin
      rdata_nxt = 16'h0000;
      if (hit_hi)
         rdata_nxt = {ACQSC_ZERO8, sr_hi};
      else if (hit_lo)
         rdata_nxt = {ACQSC_ZERO8, sr_lo};
      else if (acc_ok)
         rdata_nxt = {ACQSC_ZERO8, acc1_r};
   end

   // registered read data, zero when no read is under way
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         RDATA_O <= 16'h0000;
      else
         RDATA_O <= RD_I ? rdata_nxt : 16'h0000;
   end

   // byte access to chain control flagged for one cycle
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         ACC_ERR_O <= 1'b0;
      else
         ACC_ERR_O <= (RD_I || WR_I) && hit_acc && !WIDE_I;
   end

endmodule

// ===== verif/acqsc_top_sva.sv
// checker for the acquisition status and chain control block
`timescale 1ns/1ps
module acqsc_top_sva
   import acqsc_pkg::*;
(
   input wire logic        REF_CLK_I,
   input wire logic        RST_N_I,
   input wire logic [15:0] ADDR_I,
   input wire logic        WR_I,
   input wire logic        RD_I,
   input wire logic        WIDE_I,
   input wire logic [15:0] WDATA_I,
   input wire logic [15:0] RDATA_O,
   input wire logic        ACC_ERR_O,
   input wire logic        CUR_DONE_I,
   input wire logic [15:0] VOLT_RESULT_I,
   input wire logic [3:0]  CHOP_ACTIVE_I,
   input wire logic        TEMP_COMPENSATION_ENABLE_O,
   input wire logic        AUTO_GAIN_ENABLE_O,
   input wire logic [2:0]  MANUAL_GAIN_SETTING_I,
   input wire logic [2:0]  MANUAL_GAIN_O
);
   // ****************************************************
   // address decode and properties
   // ****************************************************
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   wire win   = ADDR_I[15:8] == 8'h02 || ADDR_I[15:8] == 8'h03;
   wire acc   = win && ADDR_I[7:0] == ACQSC_OFF_ACC1;
   wire wfull = WR_I && acc && WIDE_I;
   a_err_on_byte: assert property (
      (WR_I || RD_I) && acc && !WIDE_I |=> ACC_ERR_O)
      else $error("byte access to chain control not flagged");
   a_byte_no_write: assert property (
      WR_I && acc && !WIDE_I |=> $stable(TEMP_COMPENSATION_ENABLE_O))
      else $error("byte write changed chain control");
   a_unmapped_zero: assert property (
      RD_I && !win |=> RDATA_O == 16'h0000)
      else $error("read outside windows not zero");
   a_mask_blocks_bit: assert property (
      wfull && !WDATA_I[15] |=> $stable(TEMP_COMPENSATION_ENABLE_O))
      else $error("masked control bit changed");
   a_temp_comp_written: assert property (
      wfull && WDATA_I[15] |=> TEMP_COMPENSATION_ENABLE_O == $past(WDATA_I[7]))
      else $error("temperature compensation not written");
   a_auto_gain_written: assert property (
      wfull && WDATA_I[8] |=> AUTO_GAIN_ENABLE_O == $past(WDATA_I[0]))
      else $error("auto gain not written");
   a_gain_select: assert property (
      MANUAL_GAIN_O == (AUTO_GAIN_ENABLE_O ? 3'h0 : MANUAL_GAIN_SETTING_I))
      else $error("manual gain selection wrong");
   a_upper_zero: assert property (
      RD_I && acc && WIDE_I |=> RDATA_O[15:8] == 8'h00)
      else $error("mask bits read nonzero");
   a_lo_status: assert property (
      RD_I && win && ADDR_I[7:0] == ACQSC_OFF_SR_LO |=> RDATA_O[4:0] ==
      {($past(VOLT_RESULT_I) >= ACQSC_VHIGH_CODE), $past(CHOP_ACTIVE_I)})
      else $error("low status byte wrong");
   a_cur_done_seen: assert property (
      RD_I && win && ADDR_I[7:0] == ACQSC_OFF_SR_HI && $past(CUR_DONE_I)
      |=> RDATA_O[ACQSC_B_CUR_DONE])
      else $error("current done flag missing");
   c_full_write: cover property (wfull);
   c_byte_err: cover property (ACC_ERR_O);
   c_vth_seen: cover property (RD_I ##1 RDATA_O[ACQSC_B_VHIGH]);
endmodule
bind acqsc_top acqsc_top_sva acqsc_top_sva_i (.REF_CLK_I(REF_CLK_I),
   .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
   .WIDE_I(WIDE_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
   .ACC_ERR_O(ACC_ERR_O), .CUR_DONE_I(CUR_DONE_I),
   .VOLT_RESULT_I(VOLT_RESULT_I), .CHOP_ACTIVE_I(CHOP_ACTIVE_I),
   .TEMP_COMPENSATION_ENABLE_O(TEMP_COMPENSATION_ENABLE_O),
   .AUTO_GAIN_ENABLE_O(AUTO_GAIN_ENABLE_O),
   .MANUAL_GAIN_SETTING_I(MANUAL_GAIN_SETTING_I),
   .MANUAL_GAIN_O(MANUAL_GAIN_O));

// ===== verif/testbench.sv
// self-checking testbench for the acquisition status and chain control
`timescale 1ns/1ps
`define CHK(n, e, g) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("MISMATCH %s exp %h got %h", n, e, g); \
      end \
   end
module testbench;
   // ****************************************************
   // stimulus, instance and scenarios
   // ****************************************************
   logic        clk, rst_n, wr_s, rd_s, wide, shunt, shen, norm;
   logic [15:0] addr, wdata, vres, d;
   logic [6:0]  pls;
   logic [3:0]  chop;
   logic [2:0]  mgs;
   wire         err;
   wire  [15:0] rdata;
   wire  [2:0]  mg;
   wire  [7:0]  ctl;
   int          err_count, check_count;
   acqsc_top acqsc_top_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
      .WR_I(wr_s), .RD_I(rd_s), .WIDE_I(wide), .WDATA_I(wdata),
      .RDATA_O(rdata), .ACC_ERR_O(err), .GAIN_CHANGED_I(pls[6]),
      .ETMP_DONE_I(pls[5]), .ITMP_DONE_I(pls[4]), .VOLT_DONE_I(pls[3]),
      .CUR_DONE_I(pls[2]), .VOLT_RESULT_RD_I(pls[1]),
      .CUR_RESULT_RD_I(pls[0]), .VOLT_RESULT_I(vres),
      .SHUNT_OPEN_I(shunt), .SHUNT_CHECK_ENABLE_I(shen),
      .NORMAL_MODE_I(norm), .MANUAL_GAIN_SETTING_I(mgs),
      .CHOP_ACTIVE_I(chop), .TEMP_COMPENSATION_ENABLE_O(ctl[7]),
      .VOLTAGE_COMPENSATION_ENABLE_O(ctl[6]),
      .CURRENT_COMPENSATION_ENABLE_O(ctl[5]), .LOWPASS_ENABLE_O(ctl[4]),
      .EXT_TEMP_CHOPPER_O(ctl[3]), .INT_TEMP_CHOPPER_O(ctl[2]),
      .VOLT_CURR_CHOPPER_ENABLE_O(ctl[1]), .AUTO_GAIN_ENABLE_O(ctl[0]),
      .MANUAL_GAIN_O(mg));
   // one bus cycle, read or write; a read returns the data in d
   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [15:0] v, input logic wd);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wide <= wd;
      wr_s <= w;
      rd_s <= !w;
      @(posedge clk);
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   // one-cycle pulses on the event inputs
   task automatic pulse(input logic [6:0] v);
      @(posedge clk);
      pls <= v;
      @(posedge clk);
      pls <= 7'h00;
   endtask
   task automatic test_reset_and_byte();
      acc(1'b0, 16'h025c, 16'h0000, 1'b1);
      `CHK("acc1 reset", 16'h00e1, d)
      `CHK("gain out", 3'h0, mg)
      acc(1'b1, 16'h025c, 16'hff00, 1'b0);
      `CHK("byte err", 1'b1, err)
      acc(1'b0, 16'h025c, 16'h0000, 1'b0);
      `CHK("byte read", 16'h0000, d)
      `CHK("ctl kept", 8'he1, ctl)
      $display("test reset and byte done");
   endtask
   task automatic test_mask();
      acc(1'b1, 16'h025c, 16'h8000, 1'b1);
      acc(1'b0, 16'h035c, 16'h0000, 1'b1);
      `CHK("acc1 temp comp", 16'h0061, d)
      acc(1'b1, 16'h025c, 16'h7f00, 1'b1);
      `CHK("ctl clear", 8'h00, ctl)
      `CHK("gain manual", 3'h5, mg)
      acc(1'b1, 16'h025c, 16'hfffe, 1'b1);
      acc(1'b0, 16'h025c, 16'h0000, 1'b1);
      `CHK("acc1 set", 16'h00fe, d)
      `CHK("ctl set", 8'hfe, ctl)
      $display("test mask done");
   endtask
   task automatic test_flags();
      pulse(7'h7c);
      acc(1'b1, 16'h025a, 16'h0001, 1'b1);
      acc(1'b0, 16'h025a, 16'h0000, 1'b1);
      `CHK("flags part", 16'h004e, d)
      acc(1'b1, 16'h025a, 16'h00ff, 1'b1);
      pulse(7'h0c);
      acc(1'b0, 16'h025a, 16'h0000, 1'b1);
      `CHK("overrun", 16'h0033, d)
      acc(1'b1, 16'h025a, 16'h00ff, 1'b1);
      pulse(7'h03);
      pulse(7'h0c);
      acc(1'b0, 16'h025a, 16'h0000, 1'b1);
      `CHK("no overrun", 16'h0003, d)
      $display("test flags done");
   endtask
   task automatic test_low();
      @(posedge clk);
      {vres, chop, shunt, shen, norm} <= {16'hdac0, 4'ha, 3'h7};
      acc(1'b0, 16'h025b, 16'h0000, 1'b1);
      `CHK("lo set", 16'h009a, d)
      @(posedge clk);
      {vres, chop, shen} <= {16'hdabf, 4'h5, 1'b0};
      acc(1'b1, 16'h025b, 16'h00ff, 1'b1);
      acc(1'b0, 16'h035b, 16'h0000, 1'b1);
      `CHK("lo clear", 16'h0005, d)
      // shunt open and check enabled, but not in normal mode
      @(posedge clk);
      {shen, norm} <= 2'h2;
      acc(1'b0, 16'h025b, 16'h0000, 1'b1);
      `CHK("lo not normal", 16'h0005, d)
      acc(1'b0, 16'h045c, 16'h0000, 1'b1);
      `CHK("unmapped", 16'h0000, d)
      $display("test low done");
   endtask
   // reset in mid-run brings back the reset control value and clears flags
   task automatic test_mid_reset();
      pulse(7'h20);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      `CHK("ctl again", 8'he1, ctl)
      acc(1'b0, 16'h025c, 16'h0000, 1'b1);
      `CHK("acc1 again", 16'h00e1, d)
      acc(1'b0, 16'h025a, 16'h0000, 1'b1);
      `CHK("flags reset", 16'h0000, d)
      $display("test mid reset done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // clock of 4 ns
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // watchdog cuts a hang short
   initial
   begin
      repeat (3000) @(posedge clk);
      err_count++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      {rst_n, wr_s, rd_s, wide, shunt, shen, norm, pls, chop} = '0;
      {addr, wdata, vres} = '0;
      mgs = 3'h5;
      err_count = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      test_reset_and_byte();
      test_mask();
      test_flags();
      test_low();
      test_mid_reset();
      report_and_stop();
   end
endmodule
